// file: hw/pwr_mgr_pkg.sv
// Constants, register map and types of the dual supply mode manager
package pwr_mgr_pkg;
  localparam int CLK_MHZ = 100;
  localparam int PLL_MHZ = 48;
  localparam int CORE_MAX_USB_MHZ = 8;
  localparam int CORE_MAX_SA_MHZ = 6;
  localparam int COPROC_USB_MHZ = 24;
  localparam int COPROC_SA_MHZ = 6;
  localparam int DIV_W = 5;
  // Dividers round up so no derived rate exceeds its figure
  localparam logic [DIV_W-1:0] CORE_DIV_USB =
    DIV_W'((CLK_MHZ + CORE_MAX_USB_MHZ - 1) / CORE_MAX_USB_MHZ);
  localparam logic [DIV_W-1:0] CORE_DIV_SA =
    DIV_W'((CLK_MHZ + CORE_MAX_SA_MHZ - 1) / CORE_MAX_SA_MHZ);
  localparam logic [DIV_W-1:0] COPROC_DIV_USB =
    DIV_W'((CLK_MHZ + COPROC_USB_MHZ - 1) / COPROC_USB_MHZ);
  localparam logic [DIV_W-1:0] COPROC_DIV_SA =
    DIV_W'((CLK_MHZ + COPROC_SA_MHZ - 1) / COPROC_SA_MHZ);
  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] RST_DLY_SA_CYC = 10'h200;
  localparam logic [CNT_W-1:0] RST_DLY_USB_CYC = 10'h100;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_POWER_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CLOCK_CONFIG = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_MODE_STATUS = 8'h08;
  localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
  localparam logic [DIV_W-1:0] CLOCK_CONFIG_RESET = 5'h00;
  localparam int BIT_UPPER_FLAG = 7;
  localparam int BIT_LOWER_FLAG = 6;
  localparam int BIT_CABLE_FLAG = 5;
  localparam int BIT_PLUG_IRQ_EN = 4;
  localparam int BIT_LEVEL_LO = 2;
  localparam int BIT_DETECTOR_OFF = 1;
  localparam int BIT_REGULATOR_ON = 0;
  typedef enum logic [1:0] {
    MODE_RESET, MODE_SINGLE, MODE_STANDALONE, MODE_USB
  } mode_t;
endpackage

// file: hw/pwr_ctrl_if.sv
// Control and status carrier between register slave and mode logic
`timescale 1ns/10ps
interface pwr_ctrl_if;
  import pwr_mgr_pkg::*;
  logic plug_irq_enable;
  logic [1:0] card_regulator_level;
  logic detector_off;
  logic card_regulator_on;
  logic [DIV_W-1:0] core_div_req;
  logic [2:0] flags;
  logic [3:0] mode_status;
  logic sys_reset;
  modport regs (
    output plug_irq_enable, card_regulator_level, detector_off,
    output card_regulator_on, core_div_req,
    input flags, mode_status, sys_reset
  );
  modport core (
    input plug_irq_enable, card_regulator_level, detector_off,
    input card_regulator_on, core_div_req,
    output flags, mode_status, sys_reset
  );
endinterface

// file: hw/clk_rate_div.sv
// Divider giving a one-cycle enable pulse every div cycles
`timescale 1ns/10ps
module clk_rate_div #(
  parameter int W = 5
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [W-1:0] div,
  output logic tick
);
  logic [W-1:0] cnt;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
      tick <= 1'b0;
    end else if (cnt + W'(1) >= div) begin
      cnt <= '0;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + W'(1);
      tick <= 1'b0;
    end
  end
endmodule

// file: hw/apb_pwr_regs.sv
// APB slave holding the power control and clock configuration registers
`timescale 1ns/10ps
module apb_pwr_regs (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pwr_mgr_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  pwr_ctrl_if.regs ctl
);
  import pwr_mgr_pkg::*;
  logic hit;
  logic wr;
  logic [31:0] rd;
  always_comb begin
    hit = 1'b1;
    rd = '0;
    unique case (paddr)
      OFS_POWER_CONTROL: rd[7:0] = {ctl.flags, ctl.plug_irq_enable,
        ctl.card_regulator_level, ctl.detector_off, ctl.card_regulator_on};
      OFS_CLOCK_CONFIG: rd[DIV_W-1:0] = ctl.core_div_req;
      OFS_MODE_STATUS: rd[3:0] = ctl.mode_status;
      default: hit = 1'b0;
    endcase
  end
  assign wr = psel && penable && pready && pwrite && !pslverr;
  // Answer is taken at the first access edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        pslverr <= !hit;
        prdata <= (hit && !pwrite) ? rd : 32'h0000_0000;
      end
    end
  end
  // Software reset restores defaults like a power-on
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctl.plug_irq_enable <= POWER_CONTROL_RESET[BIT_PLUG_IRQ_EN];
      ctl.card_regulator_level <= POWER_CONTROL_RESET[BIT_LEVEL_LO +: 2];
      ctl.detector_off <= POWER_CONTROL_RESET[BIT_DETECTOR_OFF];
      ctl.card_regulator_on <= POWER_CONTROL_RESET[BIT_REGULATOR_ON];
      ctl.core_div_req <= CLOCK_CONFIG_RESET;
    end else if (ctl.sys_reset) begin
      ctl.plug_irq_enable <= POWER_CONTROL_RESET[BIT_PLUG_IRQ_EN];
      ctl.card_regulator_level <= POWER_CONTROL_RESET[BIT_LEVEL_LO +: 2];
      ctl.detector_off <= POWER_CONTROL_RESET[BIT_DETECTOR_OFF];
      ctl.card_regulator_on <= POWER_CONTROL_RESET[BIT_REGULATOR_ON];
      ctl.core_div_req <= CLOCK_CONFIG_RESET;
    end else if (wr && paddr == OFS_POWER_CONTROL) begin
      ctl.plug_irq_enable <= pwdata[BIT_PLUG_IRQ_EN];
      ctl.card_regulator_level <= pwdata[BIT_LEVEL_LO +: 2];
      ctl.detector_off <= pwdata[BIT_DETECTOR_OFF];
      ctl.card_regulator_on <= pwdata[BIT_REGULATOR_ON];
    end else if (wr && paddr == OFS_CLOCK_CONFIG) begin
      ctl.core_div_req <= pwdata[DIV_W-1:0];
    end
  end
endmodule

// file: hw/usb_dual_supply_mode_manager.sv
// Supply mode manager: mode sequencing, detector flags, switch pin, clocks
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/10ps
module usb_dual_supply_mode_manager (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pwr_mgr_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic upper_det_in,
  input wire logic lower_det_in,
  input wire logic switch_fn_sel,
  input wire logic sw_reset_req,
  input wire logic pll_lock,
  input wire logic card_supply_present,
  input wire logic port_f_bit4_out,
  input wire logic port_f_bit4_oe,
  input wire logic usb_switch_n_i,
  output logic usb_switch_n_o,
  output logic usb_switch_n_oe,
  output logic port_f_bit4_in,
  output logic sys_reset,
  output logic ports_hiz,
  output logic pll_enable,
  output logic usb_if_enable,
  output logic clk_src_pll,
  output logic core_clk_en,
  output logic coproc_clk_en,
  output logic plug_irq,
  output logic halt_wake,
  output logic detector_power_on,
  output logic card_regulator_en,
  output logic [1:0] card_regulator_level,
  output logic card_io_tie_gnd,
  output logic [1:0] mode_code
);
  import pwr_mgr_pkg::*;

  pwr_ctrl_if ctl ();

  mode_t state;
  mode_t next_state;
  logic target_usb;
  logic next_target;
  logic por_pending;
  logic [CNT_W-1:0] hold_cnt;
  logic [CNT_W-1:0] hold_len;
  logic hold_done;
  logic cable_flag;
  logic upper_flag;
  logic lower_flag;
  logic cable_prev;
  logic [DIV_W-1:0] core_lim;
  logic [DIV_W-1:0] core_div;
  logic [DIV_W-1:0] coproc_div;
  logic core_tick;
  logic coproc_tick;
  logic drive_switch;
  logic pll_on;

  apb_pwr_regs u_regs (
    .core_clk(core_clk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .ctl(ctl.regs)
  );

  // Detector flags; the cable flag has hysteresis between the two thresholds
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      upper_flag <= 1'b0;
      lower_flag <= 1'b0;
      cable_flag <= 1'b0;
    end else if (ctl.detector_off) begin
      upper_flag <= 1'b1;
      lower_flag <= 1'b1;
      cable_flag <= 1'b1;
    end else begin
      upper_flag <= upper_det_in;
      lower_flag <= lower_det_in;
      if (upper_det_in) begin
        cable_flag <= 1'b1;
      end else if (!lower_det_in) begin
        cable_flag <= 1'b0;
      end
    end
  end

  assign ctl.flags = {upper_flag, lower_flag, cable_flag};

  // Each cable flag edge requests an interrupt and a Halt wake-up
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cable_prev <= 1'b0;
      plug_irq <= 1'b0;
      halt_wake <= 1'b0;
    end else begin
      cable_prev <= cable_flag;
      plug_irq <= ctl.plug_irq_enable && (cable_flag != cable_prev);
      halt_wake <= ctl.plug_irq_enable && (cable_flag != cable_prev);
    end
  end

  // Reset delay: crystal cycles stand-alone, PLL cycles after lock
  assign pll_on = !switch_fn_sel || target_usb;
  assign hold_len = pll_on ? RST_DLY_USB_CYC : RST_DLY_SA_CYC;
  // At or past the end, so a shorter delay chosen mid-count cannot wrap the counter
  assign hold_done = (hold_cnt >= hold_len - CNT_W'(1));

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hold_cnt <= '0;
    end else if (sw_reset_req || state != MODE_RESET) begin
      hold_cnt <= '0;
    end else if (!pll_on || pll_lock) begin
      hold_cnt <= hold_cnt + CNT_W'(1);
    end
  end

  always_comb begin
    next_state = state;
    next_target = target_usb;
    if (sw_reset_req) begin
      next_state = MODE_RESET;
      next_target = switch_fn_sel && cable_flag;
    end else begin
      unique case (state)
        MODE_RESET: begin
          if (por_pending) begin
            next_target = switch_fn_sel && cable_flag;
          end
          if (hold_done && !por_pending) begin
            if (!switch_fn_sel) begin
              next_state = MODE_SINGLE;
            end else if (target_usb) begin
              next_state = MODE_USB;
            end else begin
              next_state = MODE_STANDALONE;
            end
          end
        end
        MODE_SINGLE: next_state = MODE_SINGLE;
        MODE_STANDALONE: next_state = MODE_STANDALONE;
        MODE_USB: next_state = MODE_USB;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= MODE_RESET;
      target_usb <= 1'b0;
      por_pending <= 1'b1;
    end else begin
      state <= next_state;
      target_usb <= next_target;
      por_pending <= 1'b0;
    end
  end

  assign ctl.sys_reset = (state == MODE_RESET);
  assign ctl.mode_status = {pll_enable, sys_reset, mode_code};
  assign drive_switch = switch_fn_sel && next_target &&
    (next_state == MODE_RESET || next_state == MODE_USB);

  // Mode outputs registered from the next state so they track the state
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sys_reset <= 1'b1;
      ports_hiz <= 1'b1;
      pll_enable <= 1'b0;
      usb_if_enable <= 1'b0;
      clk_src_pll <= 1'b0;
      mode_code <= 2'h0;
    end else begin
      sys_reset <= (next_state == MODE_RESET);
      ports_hiz <= (next_state == MODE_RESET);
      pll_enable <= (next_state == MODE_SINGLE) || (next_state == MODE_USB) ||
        ((next_state == MODE_RESET) && (!switch_fn_sel || next_target));
      usb_if_enable <= (next_state == MODE_SINGLE) || (next_state == MODE_USB);
      clk_src_pll <= (next_state == MODE_SINGLE) || (next_state == MODE_USB);
      mode_code <= 2'(next_state);
    end
  end

  // Switch pin drives low in USB mode and in a reset heading for USB, floats otherwise; else it is port_f_bit4
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      usb_switch_n_o <= 1'b0;
      usb_switch_n_oe <= 1'b0;
      port_f_bit4_in <= 1'b0;
    end else begin
      port_f_bit4_in <= usb_switch_n_i;
      if (switch_fn_sel) begin
        usb_switch_n_o <= 1'b0;
        usb_switch_n_oe <= drive_switch;
      end else begin
        usb_switch_n_o <= port_f_bit4_out;
        usb_switch_n_oe <= port_f_bit4_oe && (next_state != MODE_RESET);
      end
    end
  end

  // Clock rate limits per mode; software may only slow the core further
  assign core_lim = (state == MODE_STANDALONE) ? CORE_DIV_SA : CORE_DIV_USB;
  assign core_div = (ctl.core_div_req > core_lim) ? ctl.core_div_req : core_lim;
  assign coproc_div = (state == MODE_USB) ? COPROC_DIV_USB : COPROC_DIV_SA;

  clk_rate_div #(
    .W(DIV_W)
  ) u_core_div (
    .core_clk(core_clk),
    .rst(rst),
    .div(core_div),
    .tick(core_tick)
  );

  clk_rate_div #(
    .W(DIV_W)
  ) u_coproc_div (
    .core_clk(core_clk),
    .rst(rst),
    .div(coproc_div),
    .tick(coproc_tick)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      core_clk_en <= 1'b0;
      coproc_clk_en <= 1'b0;
    end else begin
      core_clk_en <= core_tick;
      coproc_clk_en <= coproc_tick;
    end
  end

  // Card rail regulator and detector power
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      card_regulator_en <= 1'b0;
      card_regulator_level <= 2'h0;
      card_io_tie_gnd <= 1'b1;
      detector_power_on <= 1'b0;
    end else begin
      card_regulator_en <= ctl.card_regulator_on;
      card_regulator_level <= ctl.card_regulator_level;
      card_io_tie_gnd <= !card_supply_present;
      detector_power_on <= !ctl.detector_off;
    end
  end

  AST_STANDALONE_FLOAT: assert property (@(posedge core_clk) disable iff (rst)
    (state == MODE_STANDALONE && switch_fn_sel) |-> !usb_switch_n_oe)
    else $error("switch pin driven in stand-alone mode");
  AST_USB_DRIVE_LOW: assert property (@(posedge core_clk) disable iff (rst)
    (state == MODE_USB && switch_fn_sel) |-> (usb_switch_n_oe && !usb_switch_n_o))
    else $error("switch pin not low in USB mode");
  AST_RESET_TO_USB: assert property (@(posedge core_clk) disable iff (rst)
    (sw_reset_req && switch_fn_sel && cable_flag) |=> usb_switch_n_oe && sys_reset)
    else $error("switch not driven during reset into USB");
  AST_RESET_LEAVE_USB: assert property (@(posedge core_clk) disable iff (rst)
    (sw_reset_req && switch_fn_sel && !cable_flag) |=> !usb_switch_n_oe && !pll_enable)
    else $error("switch or PLL left on during reset to stand-alone");
  AST_STANDALONE_CLOCKS: assert property (@(posedge core_clk) disable iff (rst)
    (state == MODE_STANDALONE) |-> (!pll_enable && !usb_if_enable &&
      core_div >= CORE_DIV_SA && coproc_div == COPROC_DIV_SA))
    else $error("stand-alone clock limits broken");
  AST_USB_CLOCKS: assert property (@(posedge core_clk) disable iff (rst)
    (state == MODE_USB) |-> (pll_enable && usb_if_enable && coproc_div == COPROC_DIV_USB))
    else $error("USB mode clocks wrong");
  AST_SINGLE_CLOCKS: assert property (@(posedge core_clk) disable iff (rst)
    (state == MODE_SINGLE) |-> (pll_enable && usb_if_enable && core_div >= CORE_DIV_USB))
    else $error("single supply clocks wrong");
  AST_EDGE_IRQ: assert property (@(posedge core_clk) disable iff (rst)
    (ctl.plug_irq_enable && $changed(cable_flag)) |=> (plug_irq && halt_wake))
    else $error("cable flag edge gave no interrupt");
  AST_NO_IRQ_DISABLED: assert property (@(posedge core_clk) disable iff (rst)
    !ctl.plug_irq_enable |=> !plug_irq)
    else $error("interrupt while disabled");
  AST_HIZ_RESET: assert property (@(posedge core_clk) disable iff (rst)
    $rose(sys_reset) |-> ports_hiz [*2])
    else $error("ports not high impedance in reset");
  AST_DETECTOR_OFF: assert property (@(posedge core_clk) disable iff (rst)
    ctl.detector_off |=> (ctl.flags == 3'h7))
    else $error("flags not forced with detector off");
  AST_TIE_GND: assert property (@(posedge core_clk) disable iff (rst)
    !card_supply_present |=> card_io_tie_gnd)
    else $error("card lines not tied low");
  AST_REG_OFF: assert property (@(posedge core_clk) disable iff (rst)
    !ctl.card_regulator_on |=> !card_regulator_en)
    else $error("regulator on while disabled");
  AST_HOLD_LEN: assert property (@(posedge core_clk) disable iff (rst)
    (state == MODE_RESET && !pll_on && hold_cnt != '0) |-> hold_cnt < RST_DLY_SA_CYC)
    else $error("stand-alone reset delay overrun");

  COV_ENTER_USB: cover property (@(posedge core_clk) disable iff (rst)
    state == MODE_RESET ##1 state == MODE_USB);
  COV_ENTER_STANDALONE: cover property (@(posedge core_clk) disable iff (rst)
    state == MODE_RESET ##1 state == MODE_STANDALONE);
  COV_PLUG_IRQ: cover property (@(posedge core_clk) disable iff (rst)
    state == MODE_STANDALONE && plug_irq);
  COV_UNPLUG_IRQ: cover property (@(posedge core_clk) disable iff (rst)
    state == MODE_USB && plug_irq);
endmodule

// file: dv/usb_switch_model.sv
// Far-side model: external supply switch transistor and storage switch timing
`timescale 1ns/10ps
module usb_switch_model #(
  parameter int STORE_DLY = 64
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic drv_o,
  input wire logic drv_oe,
  output logic pin,
  output logic switch_on,
  output logic storage_on
);
  int cnt;
  logic last_on;
  // Gate pull-up keeps the transistor off whenever the pin is released
  assign pin = drv_oe ? drv_o : 1'b1;
  assign switch_on = ~pin;
  // Storage switch closes only once the supply has settled after a change
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      last_on <= 1'b0;
      storage_on <= 1'b0;
    end else if (switch_on != last_on) begin
      last_on <= switch_on;
      cnt <= 0;
      storage_on <= 1'b0;
    end else if (cnt < STORE_DLY) begin
      cnt <= cnt + 1;
    end else begin
      storage_on <= 1'b1;
    end
  end
endmodule

// file: dv/usb_dual_supply_mode_manager_tb.sv
// Self-checking bench of the supply mode manager
`timescale 1ns/10ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errors++; $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
module usb_dual_supply_mode_manager_tb;
  import pwr_mgr_pkg::*;
  logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, err;
  logic upper_det_in = 0, lower_det_in = 0, switch_fn_sel = 0, sw_reset_req = 0;
  logic pll_lock = 1, card_supply_present = 1, port_f_bit4_out = 0, port_f_bit4_oe = 0;
  logic usb_switch_n_i, usb_switch_n_o, usb_switch_n_oe, port_f_bit4_in, sys_reset, ports_hiz;
  logic pll_enable, usb_if_enable, clk_src_pll, core_clk_en, coproc_clk_en, plug_irq;
  logic halt_wake, detector_power_on, card_regulator_en, card_io_tie_gnd, switch_on, storage_on;
  logic [1:0] card_regulator_level, mode_code;
  int errors = 0, compares = 0, per;

  always #5 core_clk = ~core_clk;

  usb_dual_supply_mode_manager u_usb_dual_supply_mode_manager (.core_clk, .rst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .upper_det_in,
    .lower_det_in, .switch_fn_sel, .sw_reset_req, .pll_lock, .card_supply_present,
    .port_f_bit4_out, .port_f_bit4_oe, .usb_switch_n_i, .usb_switch_n_o, .usb_switch_n_oe,
    .port_f_bit4_in, .sys_reset, .ports_hiz, .pll_enable, .usb_if_enable, .clk_src_pll,
    .core_clk_en, .coproc_clk_en, .plug_irq, .halt_wake, .detector_power_on,
    .card_regulator_en, .card_regulator_level, .card_io_tie_gnd, .mode_code);

  usb_switch_model u_usb_switch_model (.core_clk, .rst, .drv_o(usb_switch_n_o),
    .drv_oe(usb_switch_n_oe), .pin(usb_switch_n_i), .switch_on(switch_on),
    .storage_on(storage_on));

  task automatic give_verdict();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Answer and read data are taken at the edge where pready is sampled high
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  function automatic logic pick(input int s);
    return s == 0 ? core_clk_en : (s == 1 ? coproc_clk_en : plug_irq);
  endfunction

  task automatic wait_hi(input int s, input int lim, output int n);
    n = 0;
    while (pick(s) !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
  endtask

  // Spacing of enable pulses, in cycles
  task automatic period(input int s);
    wait_hi(s, 64, per);
    cyc(1);
    wait_hi(s, 64, per);
    per = per + 1;
  endtask

  task automatic wait_mode(input logic [1:0] m);
    int n;
    n = 0;
    while (mode_code !== m && n < 2000) begin
      cyc(1);
      n++;
    end
    if (mode_code !== m) errors++;
  endtask

  task automatic pulse_reset();
    @(posedge core_clk);
    sw_reset_req <= 1'b1;
    @(posedge core_clk);
    sw_reset_req <= 1'b0;
    cyc(1);
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    wait_mode(MODE_SINGLE);
    `CHK(mode_code, MODE_SINGLE)
    `CHK({pll_enable, usb_if_enable, clk_src_pll}, 3'b111)
    period(0);
    `CHK(per, int'(CORE_DIV_USB))
    @(posedge core_clk);
    port_f_bit4_oe <= 1'b1;
    cyc(3);
    `CHK({usb_switch_n_oe, usb_switch_n_o, port_f_bit4_in}, 3'b100)
    @(posedge core_clk);
    port_f_bit4_oe <= 1'b0;
    cyc(3);
    `CHK({usb_switch_n_oe, port_f_bit4_in}, 2'b01)
    apb(1'b0, OFS_POWER_CONTROL, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    apb(1'b0, 8'h0C, 32'h0000_0000);
    `CHK({err, rd}, {1'b1, 32'h0000_0000})
    @(posedge core_clk);
    switch_fn_sel <= 1'b1;
    pulse_reset();
    `CHK({sys_reset, ports_hiz, usb_switch_n_oe}, 3'b110)
    wait_mode(MODE_STANDALONE);
    `CHK(mode_code, MODE_STANDALONE)
    `CHK({pll_enable, usb_if_enable, clk_src_pll, usb_switch_n_oe, usb_switch_n_i}, 5'b00001)
    period(0);
    `CHK(per, int'(CORE_DIV_SA))
    period(1);
    `CHK(per, int'(COPROC_DIV_SA))
    apb(1'b1, OFS_POWER_CONTROL, 32'h0000_0010);
    @(posedge core_clk);
    upper_det_in <= 1'b1;
    lower_det_in <= 1'b1;
    wait_hi(2, 6, per);
    `CHK(per < 6, 1'b1)
    `CHK(halt_wake, 1'b1)
    cyc(1);
    `CHK(plug_irq, 1'b0)
    apb(1'b0, OFS_POWER_CONTROL, 32'h0000_0000);
    `CHK(rd, 32'h0000_00F0)
    pulse_reset();
    `CHK({sys_reset, ports_hiz, usb_switch_n_oe, usb_switch_n_o}, 4'b1110)
    `CHK(storage_on, 1'b0)
    wait_mode(MODE_USB);
    `CHK(mode_code, MODE_USB)
    `CHK({pll_enable, usb_if_enable, clk_src_pll, usb_switch_n_oe, usb_switch_n_o, switch_on}, 6'b111101)
    `CHK(storage_on, 1'b1)
    period(1);
    `CHK(per, int'(COPROC_DIV_USB))
    apb(1'b1, OFS_CLOCK_CONFIG, 32'h0000_0014);
    period(0);
    `CHK(per, 20)
    apb(1'b1, OFS_CLOCK_CONFIG, 32'h0000_0002);
    period(0);
    `CHK(per, int'(CORE_DIV_USB))
    apb(1'b0, OFS_MODE_STATUS, 32'h0000_0000);
    `CHK(rd, 32'h0000_000B)
    apb(1'b0, OFS_POWER_CONTROL, 32'h0000_0000);
    `CHK(rd, 32'h0000_00E0)
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, OFS_POWER_CONTROL, 32'(i * 4 + 1));
      cyc(1);
      `CHK({card_regulator_en, card_regulator_level}, {1'b1, 2'(i)})
    end
    apb(1'b1, OFS_POWER_CONTROL, 32'h0000_0010);
    cyc(1);
    `CHK(card_regulator_en, 1'b0)
    @(posedge core_clk);
    card_supply_present <= 1'b0;
    cyc(2);
    `CHK(card_io_tie_gnd, 1'b1)
    @(posedge core_clk);
    card_supply_present <= 1'b1;
    cyc(2);
    `CHK(card_io_tie_gnd, 1'b0)
    @(posedge core_clk);
    upper_det_in <= 1'b0;
    lower_det_in <= 1'b0;
    wait_hi(2, 6, per);
    `CHK(per < 6, 1'b1)
    apb(1'b0, OFS_POWER_CONTROL, 32'h0000_0000);
    `CHK(rd, 32'h0000_0010)
    apb(1'b1, OFS_POWER_CONTROL, 32'h0000_0012);
    apb(1'b0, OFS_POWER_CONTROL, 32'h0000_0000);
    `CHK(rd, 32'h0000_00F2)
    `CHK(detector_power_on, 1'b0)
    apb(1'b1, OFS_POWER_CONTROL, 32'h0000_0010);
    cyc(3);
    pulse_reset();
    `CHK({sys_reset, usb_switch_n_oe, usb_switch_n_i}, 3'b101)
    wait_mode(MODE_STANDALONE);
    `CHK({mode_code, pll_enable, clk_src_pll}, {MODE_STANDALONE, 2'b00})
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    give_verdict();
  end
endmodule
